// >>> flash_host_consts.vh
// Constants shared by the flash host sequencer and its pin synchroniser.
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH

// Command bytes written to the flash command register, and the value read from an erased byte.
`define CMD_READ_ARRAY 8'h00
`define CMD_READ_SIG 8'h90
`define CMD_ERASE 8'h20
`define CMD_ERASE_CHECK 8'hA0
`define CMD_PROGRAM 8'h40
`define CMD_PROGRAM_CHECK 8'hC0
`define CMD_RESET 8'hFF
`define ERASED_BYTE 8'hFF

// Operations requested on the user port.
`define OP_READ_ARRAY 3'h0
`define OP_READ_SIG 3'h1
`define OP_PROGRAM 3'h2
`define OP_ERASE 3'h3
`define OP_RESET 3'h4

// Array size and retry limits.
`define LAST_ADDR 17'h1FFFF
`define PROG_TRIES 10'h019
`define ERASE_TRIES 10'h3E8

// Timing in nanoseconds and microseconds, and derived counts of 40 ns cycles (rounded up).
`define CLK_NS 40
`define T_WR_SU_NS 40
`define T_WP_NS 100
`define T_WR_HD_NS 40
`define T_ACC_NS 150
`define T_REC_NS 80
`define T_VPP_NS 1000
`define T_PROG_US 10
`define T_ERASE_US 10000
`define WR_SU_CYC ((`T_WR_SU_NS + `CLK_NS - 1) / `CLK_NS)
`define WP_CYC ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define WR_HD_CYC ((`T_WR_HD_NS + `CLK_NS - 1) / `CLK_NS)
`define WR_LEN (`WR_SU_CYC + `WP_CYC + `WR_HD_CYC)
`define SYNC_LAT 3
`define RD_LEN (((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS) + `SYNC_LAT)
`define REC_CYC ((`T_REC_NS + `CLK_NS - 1) / `CLK_NS)
`define VPP_CYC ((`T_VPP_NS + `CLK_NS - 1) / `CLK_NS)
`define PROG_CYC ((`T_PROG_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define ERASE_CYC ((`T_ERASE_US * 1000 + `CLK_NS - 1) / `CLK_NS)

// Synchroniser width: eight data pins plus the supply-good pin.
`define SYNC_W 9

`endif

// >>> flash_pin_sync.v
// Three-stage synchroniser for the pins returned by the flash device.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.vh"

module flash_pin_sync (
    input wire i_clk,
    input wire i_rst_n,
    input wire [`SYNC_W-1:0] i_pin,
    output wire [`SYNC_W-1:0] o_level
);

    genvar g;

    // Each bit passes four flops; the output follows only when stages two and three agree.
    generate
        for (g = 0; g < `SYNC_W; g = g + 1)
        begin : bit_sync
            reg [2:0] sh_q;
            reg lvl_q;
            always @(posedge i_clk)
            begin
                if (!i_rst_n)
                begin
                    sh_q <= 3'h0;
                    lvl_q <= 1'b0;
                end
                else
                begin
                    sh_q <= {sh_q[1:0], i_pin[g]};
                    if (sh_q[1] == sh_q[2])
                        lvl_q <= sh_q[2];
                end
            end
            assign o_level[g] = lvl_q;
        end
    endgenerate

endmodule
`default_nettype wire

// >>> flash_host_sequencer.v
// Host sequencer that drives a byte-wide flash device through its command register pins.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.vh"

module flash_host_sequencer #(
    parameter [17:0] ERASE_CYC = `ERASE_CYC
) (
    input wire I_CORE_CLK,
    input wire I_RST_N,
    input wire I_START,
    input wire [2:0] I_OP,
    input wire [16:0] I_ADDR,
    input wire [7:0] I_DATA,
    output wire O_READY,
    output wire O_DONE,
    output wire O_OK,
    output wire [7:0] O_RDATA,
    output wire [16:0] O_ADDR,
    input wire [7:0] I_DQ,
    output wire [7:0] O_DQ,
    output wire O_DQ_OE,
    output wire O_CE_N,
    output wire O_OE_N,
    output wire O_WE_N,
    output wire O_VPP_EN,
    input wire I_VPP_GOOD
);

    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_NEXT = 5'h02;
    localparam [4:0] S_WR = 5'h04;
    localparam [4:0] S_RD = 5'h08;
    localparam [4:0] S_DLY = 5'h10;

    // Counts are integers; each use keeps only the counter's 18 bits.
    localparam integer WR_ON = `WR_SU_CYC - 1;
    localparam integer WR_OFF = `WR_SU_CYC + `WP_CYC - 1;
    localparam integer WR_END = `WR_LEN - 1;
    localparam integer RD_END = `RD_LEN - 1;
    localparam integer REC_N = `REC_CYC;
    localparam integer VPP_N = `VPP_CYC;
    localparam integer PROG_N = `PROG_CYC;

    reg [4:0] state_q;
    reg [3:0] step_q;
    reg [2:0] op_q;
    reg [16:0] addr_q;
    reg [7:0] data_q;
    reg [16:0] check_addr_q;
    reg [9:0] tries_q;
    reg [17:0] cnt_q;
    reg [17:0] lim_q;
    reg [7:0] rd_q;
    reg done_q;
    reg ok_q;
    reg [7:0] rdata_q;
    reg [16:0] pin_addr_q;
    reg [7:0] pin_dq_q;
    reg dq_oe_q;
    reg ce_n_q;
    reg oe_n_q;
    reg we_n_q;
    reg vpp_en_q;
    wire [`SYNC_W-1:0] sync_level;
    wire [7:0] dq_sync;
    wire vpp_good;

    // Data and supply-good pins come from outside the clock domain.
    flash_pin_sync u_sync (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_pin({I_VPP_GOOD, I_DQ}),
        .o_level(sync_level)
    );

    assign dq_sync = sync_level[7:0];
    assign vpp_good = sync_level[8];

    // Ready is combinational; done, ok and every pin and data output come from a flop.
    assign O_READY = (state_q == S_IDLE);
    assign O_DONE = done_q;
    assign O_OK = ok_q;
    assign O_RDATA = rdata_q;
    assign O_ADDR = pin_addr_q;
    assign O_DQ = pin_dq_q;
    assign O_DQ_OE = dq_oe_q;
    assign O_CE_N = ce_n_q;
    assign O_OE_N = oe_n_q;
    assign O_WE_N = we_n_q;
    assign O_VPP_EN = vpp_en_q;

    // Operation sequencer: S_NEXT picks the next bus cycle or wait from op and step.
    always @(posedge I_CORE_CLK)
    begin
        if (!I_RST_N)
        begin
            state_q <= S_IDLE;
            step_q <= 4'h0;
            op_q <= `OP_READ_ARRAY;
            addr_q <= 17'h00000;
            data_q <= 8'h00;
            check_addr_q <= 17'h00000;
            tries_q <= 10'h000;
            cnt_q <= 18'h00000;
            lim_q <= 18'h00000;
            rd_q <= 8'h00;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            rdata_q <= 8'h00;
            pin_addr_q <= 17'h00000;
            pin_dq_q <= 8'h00;
            dq_oe_q <= 1'b0;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            vpp_en_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (I_START)
                    begin
                        op_q <= I_OP;
                        addr_q <= I_ADDR;
                        data_q <= I_DATA;
                        check_addr_q <= 17'h00000;
                        tries_q <= 10'h000;
                        step_q <= 4'h0;
                        ok_q <= 1'b0;
                        // Without the high supply the device ignores the signature command.
                        vpp_en_q <= (I_OP == `OP_PROGRAM) || (I_OP == `OP_ERASE)
                            || (I_OP == `OP_READ_SIG);
                        // A signature read lets the supply settle before its command.
                        cnt_q <= 18'h00000;
                        lim_q <= VPP_N[17:0];
                        state_q <= (I_OP == `OP_READ_SIG) ? S_DLY : S_NEXT;
                    end
                end
                S_NEXT:
                begin
                    // Default action: advance one step and run a command write.
                    step_q <= step_q + 4'h1;
                    cnt_q <= 18'h00000;
                    state_q <= S_WR;
                    ce_n_q <= 1'b0;
                    dq_oe_q <= 1'b1;
                    pin_addr_q <= addr_q;
                    pin_dq_q <= `CMD_READ_ARRAY;
                    case (op_q)
                        `OP_READ_ARRAY, `OP_READ_SIG:
                        begin
                            if (step_q == 4'h0)
                                pin_dq_q <= (op_q == `OP_READ_SIG) ? `CMD_READ_SIG
                                    : `CMD_READ_ARRAY;
                            else if (step_q == 4'h1)
                            begin
                                // Signature mode stays set; address 0/1 picks the code.
                                ce_n_q <= 1'b0;
                                dq_oe_q <= 1'b0;
                                oe_n_q <= 1'b0;
                                state_q <= S_RD;
                            end
                            else
                            begin
                                ok_q <= 1'b1;
                                dq_oe_q <= 1'b0;
                                ce_n_q <= 1'b1;
                                vpp_en_q <= 1'b0;
                                rdata_q <= rd_q;
                                done_q <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        end
                        `OP_PROGRAM:
                        begin
                            case (step_q)
                                4'h0:
                                begin
                                    // Let the switched supply settle before any command.
                                    ce_n_q <= 1'b1;
                                    dq_oe_q <= 1'b0;
                                    lim_q <= VPP_N[17:0];
                                    state_q <= S_DLY;
                                end
                                4'h1:
                                begin
                                    if (!vpp_good)
                                    begin
                                        // Without the supply nothing would be written.
                                        ce_n_q <= 1'b1;
                                        dq_oe_q <= 1'b0;
                                        vpp_en_q <= 1'b0;
                                        done_q <= 1'b1;
                                        state_q <= S_IDLE;
                                    end
                                    else
                                        pin_dq_q <= `CMD_PROGRAM;
                                end
                                4'h2:
                                    pin_dq_q <= data_q;
                                4'h3:
                                begin
                                    ce_n_q <= 1'b1;
                                    dq_oe_q <= 1'b0;
                                    lim_q <= PROG_N[17:0];
                                    state_q <= S_DLY;
                                end
                                4'h4:
                                    pin_dq_q <= `CMD_PROGRAM_CHECK;
                                4'h5:
                                begin
                                    dq_oe_q <= 1'b0;
                                    oe_n_q <= 1'b0;
                                    state_q <= S_RD;
                                end
                                4'h6:
                                begin
                                    rdata_q <= rd_q;
                                    if (rd_q == data_q)
                                        ok_q <= 1'b1;
                                    if ((rd_q != data_q) && (tries_q != `PROG_TRIES - 10'h001))
                                    begin
                                        // Retry skips the supply settle wait.
                                        tries_q <= tries_q + 10'h001;
                                        pin_dq_q <= `CMD_PROGRAM;
                                        step_q <= 4'h2;
                                    end
                                end
                                default:
                                begin
                                    ce_n_q <= 1'b1;
                                    dq_oe_q <= 1'b0;
                                    vpp_en_q <= 1'b0;
                                    done_q <= 1'b1;
                                    state_q <= S_IDLE;
                                end
                            endcase
                        end
                        `OP_ERASE:
                        begin
                            case (step_q)
                                4'h0:
                                begin
                                    ce_n_q <= 1'b1;
                                    dq_oe_q <= 1'b0;
                                    lim_q <= VPP_N[17:0];
                                    state_q <= S_DLY;
                                end
                                4'h1:
                                begin
                                    if (!vpp_good)
                                    begin
                                        ce_n_q <= 1'b1;
                                        dq_oe_q <= 1'b0;
                                        vpp_en_q <= 1'b0;
                                        done_q <= 1'b1;
                                        state_q <= S_IDLE;
                                    end
                                    else
                                        pin_dq_q <= `CMD_ERASE;
                                end
                                4'h2:
                                    pin_dq_q <= `CMD_ERASE;
                                4'h3:
                                begin
                                    ce_n_q <= 1'b1;
                                    dq_oe_q <= 1'b0;
                                    lim_q <= ERASE_CYC;
                                    state_q <= S_DLY;
                                end
                                4'h4:
                                begin
                                    // Each byte check carries its own fresh address.
                                    pin_addr_q <= check_addr_q;
                                    pin_dq_q <= `CMD_ERASE_CHECK;
                                end
                                4'h5:
                                begin
                                    dq_oe_q <= 1'b0;
                                    oe_n_q <= 1'b0;
                                    state_q <= S_RD;
                                end
                                4'h6:
                                begin
                                    rdata_q <= rd_q;
                                    if (rd_q == `ERASED_BYTE)
                                    begin
                                        if (check_addr_q == `LAST_ADDR)
                                            ok_q <= 1'b1;
                                        else
                                        begin
                                            check_addr_q <= check_addr_q + 17'h00001;
                                            pin_addr_q <= check_addr_q + 17'h00001;
                                            pin_dq_q <= `CMD_ERASE_CHECK;
                                            step_q <= 4'h5;
                                        end
                                    end
                                    else if (tries_q != `ERASE_TRIES - 10'h001)
                                    begin
                                        // Re-arm and erase again; checking resumes at this address.
                                        tries_q <= tries_q + 10'h001;
                                        pin_dq_q <= `CMD_ERASE;
                                        step_q <= 4'h2;
                                    end
                                end
                                default:
                                begin
                                    ce_n_q <= 1'b1;
                                    dq_oe_q <= 1'b0;
                                    vpp_en_q <= 1'b0;
                                    done_q <= 1'b1;
                                    state_q <= S_IDLE;
                                end
                            endcase
                        end
                        `OP_RESET:
                        begin
                            // Two all-ones writes cancel any armed step, then read mode.
                            if (step_q < 4'h2)
                                pin_dq_q <= `CMD_RESET;
                            else if (step_q == 4'h3)
                            begin
                                ok_q <= 1'b1;
                                ce_n_q <= 1'b1;
                                dq_oe_q <= 1'b0;
                                done_q <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        end
                        default:
                        begin
                            // An unknown request only writes the read-array code.
                            if (step_q != 4'h0)
                            begin
                                ce_n_q <= 1'b1;
                                dq_oe_q <= 1'b0;
                                done_q <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        end
                    endcase
                end
                S_WR:
                begin
                    // WE pulses low only inside CE low; address steady, data held past the rise.
                    cnt_q <= cnt_q + 18'h00001;
                    we_n_q <= !((cnt_q >= WR_ON[17:0])
                        && (cnt_q < WR_OFF[17:0]));
                    if (cnt_q == WR_END[17:0])
                    begin
                        ce_n_q <= 1'b1;
                        dq_oe_q <= 1'b0;
                        cnt_q <= 18'h00000;
                        lim_q <= REC_N[17:0];
                        state_q <= S_DLY;
                    end
                end
                S_RD:
                begin
                    // Wait for access time plus synchroniser latency, then sample.
                    cnt_q <= cnt_q + 18'h00001;
                    if (cnt_q == RD_END[17:0])
                    begin
                        rd_q <= dq_sync;
                        ce_n_q <= 1'b1;
                        oe_n_q <= 1'b1;
                        cnt_q <= 18'h00000;
                        lim_q <= REC_N[17:0];
                        state_q <= S_DLY;
                    end
                end
                S_DLY:
                begin
                    cnt_q <= cnt_q + 18'h00001;
                    if (cnt_q >= lim_q - 18'h00001)
                        state_q <= S_NEXT;
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> flash_host_monitor.sv
// Checker of the flash pin protocol driven by the host sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_host_monitor #(
    parameter [17:0] ERASE_CYC = 18'd250000
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic I_START,
    input wire logic O_READY,
    input wire logic O_DONE,
    input wire logic [7:0] O_DQ,
    input wire logic O_DQ_OE,
    input wire logic [16:0] O_ADDR,
    input wire logic O_CE_N,
    input wire logic O_OE_N,
    input wire logic O_WE_N,
    input wire logic O_VPP_EN
);
    // All checks share the core clock; all but the reset check sleep in reset.
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_N);
    we_under_ce_a: assert property (!O_WE_N |-> !O_CE_N)
        else $error("write strobe without chip enable");
    we_drives_a: assert property (!O_WE_N |-> O_OE_N && O_DQ_OE)
        else $error("write strobe without data drive");
    write_stable_a: assert property (!O_WE_N && !$past(O_WE_N) |-> $stable(O_ADDR) && $stable(O_DQ))
        else $error("address or data moved in a write");
    we_width_a: assert property ($fell(O_WE_N) |-> !O_WE_N [*3] ##1 O_WE_N)
        else $error("write strobe width wrong");
    ce_lead_a: assert property ($fell(O_WE_N) |-> !$past(O_CE_N))
        else $error("chip enable did not lead write strobe");
    supply_idle_a: assert property (O_READY |-> !O_VPP_EN)
        else $error("high supply left on while idle");
    ce_gap_a: assert property ($rose(O_CE_N) |-> O_CE_N [*2])
        else $error("idle gap too short");
    oe_release_a: assert property (!O_OE_N |-> !O_DQ_OE && !O_CE_N)
        else $error("read with host driving data");
    done_pulse_a: assert property (O_DONE |=> !O_DONE)
        else $error("done longer than one cycle");
    start_taken_a: assert property (O_READY && I_START |=> !O_READY)
        else $error("request not taken");
    // Reset is checked with the disable removed, since it is the cause here.
    reset_idle_a: assert property (disable iff (1'b0)
        !I_RST_N |=> O_CE_N && O_WE_N && !O_DQ_OE && !O_VPP_EN)
        else $error("pins not idle in reset");
endmodule
bind flash_host_sequencer flash_host_monitor #(.ERASE_CYC(ERASE_CYC)) monitor (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_START(I_START), .O_READY(O_READY),
    .O_DONE(O_DONE), .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE), .O_ADDR(O_ADDR), .O_CE_N(O_CE_N),
    .O_OE_N(O_OE_N), .O_WE_N(O_WE_N), .O_VPP_EN(O_VPP_EN));
`default_nettype wire

// >>> flash_device_model.sv
// Behavioural byte-wide flash device with a command register.
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
    parameter logic [7:0] MFR_CODE = 8'h3C, // Arbitrary value.
    parameter logic [7:0] DEV_CODE = 8'hD2 // Arbitrary value.
) (
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_vpp_en,
    input wire logic i_vpp_ok,
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_vpp_good
);
    localparam logic [2:0] M_READ = 3'h0, M_SIG = 3'h1, M_SETE = 3'h2, M_EV = 3'h3;
    localparam logic [2:0] M_SETP = 3'h4, M_PV = 3'h5, M_RST = 3'h6;
    logic [7:0] mem [0:131071];
    logic [2:0] mode;
    logic [16:0] lat_addr, pa, ea;
    logic [7:0] pd, rd, last;
    logic erasing, programming;
    int prog_cnt, erase_cnt, ev_cnt;
    logic [23:0] hist;
    assign o_vpp_good = i_vpp_en & i_vpp_ok;
    // The array starts erased and the register in read mode.
    initial
    begin
        for (int k = 0; k < 131072; k++) mem[k] = 8'hFF;
        {mode, lat_addr, pa, ea, pd, last, erasing, programming, hist} = '0;
        {prog_cnt, erase_cnt, ev_cnt} = '0;
    end
    // Losing the supply drops the register back to read.
    always @(negedge o_vpp_good) mode = M_READ;
    // Address is taken at the strobe's fall.
    always @(negedge i_we_n) if (!i_ce_n) lat_addr = i_addr;
    // A running pulse ends at the next strobe rise; then the byte is decoded.
    always @(posedge i_we_n) if (!i_ce_n)
    begin
        hist = {hist[15:0], i_dq};
        if (erasing) for (int k = 0; k < 131072; k++) mem[k] = 8'hFF;
        if (programming) mem[pa] = mem[pa] & pd;
        // No stop timer here: a pulse simply lasts until the next strobe.
        erasing = 1'b0;
        programming = 1'b0;
        if (!o_vpp_good) mode = M_READ;
        else if (mode == M_SETP)
        begin
            pa = lat_addr;
            pd = i_dq;
            programming = 1'b1;
            prog_cnt++;
            mode = M_READ;
        end
        else if (mode == M_SETE && i_dq == 8'h20)
        begin
            erasing = 1'b1;
            erase_cnt++;
            mode = M_READ;
        end
        else if (mode == M_RST && i_dq == 8'hFF) mode = M_READ;
        else case (i_dq)
            8'h90: mode = M_SIG;
            8'h20: mode = M_SETE;
            8'hA0: begin mode = M_EV; ea = lat_addr; ev_cnt++; end
            8'h40: mode = M_SETP;
            8'hC0: mode = M_PV;
            8'hFF: mode = M_RST;
            default: mode = M_READ;
        endcase
    end
    // Reads follow the mode; the bus shows a changing value when released.
    assign rd = (mode == M_SIG) ? (i_addr[0] ? DEV_CODE : MFR_CODE) :
        (mode == M_EV) ? mem[ea] : (mode == M_PV) ? mem[pa] : mem[i_addr];
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~last;
    always @(posedge i_oe_n) last = rd;
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the flash host sequencer against a device model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst_n = 0, start = 0, vpp_ok = 1;
    logic [2:0] op = 0;
    logic [16:0] addr = 0;
    logic [7:0] data = 0;
    wire ready, done, ok, dq_oe, ce_n, oe_n, we_n, vpp_en, vpp_good;
    wire [7:0] rdata, dq_out, dev_dq, dq_bus;
    wire [16:0] faddr;
    int miscompares = 0, comparisons = 0, base;
    always #20 clk = ~clk;
    // The data wire follows whoever drives it.
    assign dq_bus = dq_oe ? dq_out : dev_dq;
    flash_host_sequencer #(.ERASE_CYC(18'd20)) DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_START(start), .I_OP(op), .I_ADDR(addr), .I_DATA(data), .O_READY(ready),
        .O_DONE(done), .O_OK(ok), .O_RDATA(rdata), .O_ADDR(faddr), .I_DQ(dq_bus),
        .O_DQ(dq_out), .O_DQ_OE(dq_oe), .O_CE_N(ce_n), .O_OE_N(oe_n), .O_WE_N(we_n),
        .O_VPP_EN(vpp_en), .I_VPP_GOOD(vpp_good));
    flash_device_model flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_vpp_en(vpp_en), .i_vpp_ok(vpp_ok), .i_addr(faddr), .i_dq(dq_bus),
        .o_dq(dev_dq), .o_vpp_good(vpp_good));
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One request, then a bounded wait for its done pulse.
    task automatic run_op(input logic [2:0] o, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        op = o;
        addr = a;
        data = d;
        start = 1;
        @(posedge clk);
        #1 start = 0;
        while (done !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 20000)
        begin
            miscompares++;
            conclude;
        end
    endtask
    task automatic t_sig;
        run_op(3'h1, 17'h00000, 8'h00);
        check(rdata, flash.MFR_CODE);
        run_op(3'h1, 17'h00001, 8'h00);
        check(rdata, flash.DEV_CODE);
        $display("signature test done");
    endtask
    task automatic t_prog;
        run_op(3'h2, 17'h12345, 8'h5A);
        check(ok, 1'b1);
        check(17'(flash.prog_cnt), 17'h1);
        run_op(3'h2, 17'h1FFFF, 8'hA5);
        run_op(3'h2, 17'h00003, 8'h3C);
        run_op(3'h0, 17'h1FFFF, 8'h00);
        check(rdata, 8'hA5);
        run_op(3'h0, 17'h12345, 8'h00);
        check(rdata, 8'h5A);
        $display("program test done");
    endtask
    task automatic t_fail;
        run_op(3'h2, 17'h00005, 8'h00);
        base = flash.prog_cnt;
        run_op(3'h2, 17'h00005, 8'hFF);
        check(ok, 1'b0);
        check(17'(flash.prog_cnt - base), 17'd25);
        check(rdata, 8'h00);
        $display("program failure test done");
    endtask
    task automatic t_vpp;
        vpp_ok = 0;
        run_op(3'h2, 17'h00007, 8'h00);
        check(ok, 1'b0);
        run_op(3'h3, 17'h00000, 8'h00);
        check(ok, 1'b0);
        check(17'(flash.erase_cnt), 17'h0);
        vpp_ok = 1;
        run_op(3'h0, 17'h00007, 8'h00);
        check(rdata, 8'hFF);
        $display("supply test done");
    endtask
    task automatic t_reset;
        run_op(3'h4, 17'h00000, 8'h00);
        check(flash.hist[23:8], 16'hFFFF);
        check(flash.hist[7:0], 8'h00);
        run_op(3'h7, 17'h00000, 8'h00);
        check(ok, 1'b0);
        $display("reset test done");
    endtask
    // Erase is cut short after three byte checks; a full sweep is too long.
    task automatic t_erase;
        int n;
        n = 0;
        op = 3'h3;
        start = 1;
        @(posedge clk);
        #1 start = 0;
        while (flash.ev_cnt < 3 && n < 20000)
        begin
            @(posedge clk);
            #1 n++;
        end
        check(17'(n < 20000), 17'h1);
        check(17'(flash.erase_cnt), 17'h1);
        check(flash.ea, 17'h00002);
        check(flash.mem[17'h12345], 8'hFF);
        $display("erase test done");
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        t_sig;
        t_prog;
        t_fail;
        t_vpp;
        t_reset;
        t_erase;
        conclude;
    end
endmodule
`default_nettype wire
